/* File: src/serial_port_consts.svh */
`ifndef SERIAL_PORT_CONSTS_SVH
`define SERIAL_PORT_CONSTS_SVH
`define WORD_BITS      16
`define CNT_W          5
`define CNT_ZERO       5'h00
`define CNT_ONE        5'h01
`define CNT_FULL       5'h10
`define TYPE_HI        15
`define TYPE_LO        14
`define SYNC_RESET     2'h0
`define FIFO_DEPTH     16
`endif

/* File: src/serial_port_pkg.sv */
package serial_port_pkg;
  typedef enum logic [1:0]
  {
    XFER_WR_CFG = 2'h3,
    XFER_RD_CFG = 2'h1,
    XFER_WR_DAT = 2'h2,
    XFER_RD_DAT = 2'h0
  } xfer_type_t;
  typedef struct packed
  {
    xfer_type_t  kind;
    logic [13:0] payload;
  } frame_word_t;
  typedef enum logic [1:0]
  {
    ST_IDLE  = 2'h0,
    ST_SHIFT = 2'h1,
    ST_DONE  = 2'h2
  } port_state_t;
endpackage

/* File: src/word_fifo.sv */
`timescale 1ns/1ps
`default_nettype none
module word_fifo #(
  parameter int WIDTH = 16,
  parameter int DEPTH = 16,
  parameter int AW    = $clog2(DEPTH)
) (
  input  wire logic             clk_i,
  input  wire logic             rst_n_i,
  input  wire logic             in_valid_i,
  output logic                  in_ready_o,
  input  wire logic [WIDTH-1:0] in_data_i,
  output logic                  out_valid_o,
  input  wire logic             out_ready_i,
  output logic      [WIDTH-1:0] out_data_o
);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW:0]      wr_reg;
  logic [AW:0]      rd_reg;
  wire              full_w  = (wr_reg[AW] != rd_reg[AW]) && (wr_reg[AW-1:0] == rd_reg[AW-1:0]);
  wire              empty_w = (wr_reg == rd_reg);
  wire              push_w  = in_valid_i && !full_w;
  wire              pop_w   = out_ready_i && !empty_w;
  assign in_ready_o  = !full_w;
  assign out_valid_o = !empty_w;
  assign out_data_o  = mem[rd_reg[AW-1:0]];
  always_ff @(posedge clk_i)
  begin
    if (push_w)
      mem[wr_reg[AW-1:0]] <= in_data_i;
  end
  always_ff @(posedge clk_i or negedge rst_n_i)
  begin
    if (!rst_n_i)
    begin
      wr_reg <= '0;
      rd_reg <= '0;
    end
    else
    begin
      if (push_w)
        wr_reg <= wr_reg + 1'b1;
      if (pop_w)
        rd_reg <= rd_reg + 1'b1;
    end
  end
endmodule
`default_nettype wire

/* File: src/uart_host_serial_port.sv */
// Summary of operation
// - The port works with an idle-low serial clock, sampling on its rising edge and shifting on its falling edge.
// - Every complete frame is full duplex, taking one 16-bit word in while returning one 16-bit word out.
// - The first two received bits pick the transfer type: write config, read config, write data or read data.
// - The serial input is sampled on each of the first 16 rising serial clock edges while chip select is low.
// - Output bit 15 appears as chip select falls, before any clock edge.
// - Output bits 14 down to 0 change on the first 15 falling serial clock edges, one bit per edge.
// - A frame that ends before the sixteenth bit is dropped and changes nothing.
// - The received word of a complete frame is queued when chip select rises while the FIFO has room; with the FIFO full it is lost.
// - Each falling chip select edge restarts the bit count for a fresh 16-bit frame.
// - The serial output is released whenever chip select is high.
// - In a data frame the data-available flag clears at the sixteenth falling clock edge when no more data waits.
`timescale 1ns/1ps
`default_nettype none
`include "serial_port_consts.svh"
module uart_host_serial_port
  import serial_port_pkg::*;
#(
  parameter int WORD_W = `WORD_BITS,
  parameter int DEPTH  = `FIFO_DEPTH
) (
  input  wire logic              clk_i,
  input  wire logic              resetn_i,
  input  wire logic              sclk_i,
  input  wire logic              cs_n_i,
  input  wire logic              sdi_i,
  output logic                   sdo_o,
  output logic                   sdo_oe_n_o,
  input  wire logic [WORD_W-1:0] reply_i,
  input  wire logic              rx_pending_i,
  output logic                   word_valid_o,
  input  wire logic              word_ready_i,
  output frame_word_t            word_o,
  output logic                   rx_avail_o,
  output logic                   fifo_full_o
);
  logic [1:0]        rst_sync_reg;
  wire               rst_n = rst_sync_reg[1];
  logic [1:0]        sclk_sync_reg;
  logic [1:0]        cs_sync_reg;
  logic [1:0]        sdi_sync_reg;
  logic              sclk_prev_reg;
  logic              cs_prev_reg;
  logic [`CNT_W-1:0] cnt_reg;
  logic [WORD_W-1:0] rx_reg;
  logic [WORD_W-1:0] tx_reg;
  logic              sdo_reg;
  logic              oe_n_reg;
  logic              push_reg;
  logic              avail_reg;
  logic              data_frame_reg;
  port_state_t       state_reg;
  logic              in_ready;
  always_ff @(posedge clk_i or negedge resetn_i)
  begin
    if (!resetn_i)
      rst_sync_reg <= `SYNC_RESET;
    else
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      sclk_sync_reg <= 2'h0;
      cs_sync_reg   <= 2'h3;
      sdi_sync_reg  <= 2'h0;
      sclk_prev_reg <= 1'b0;
      cs_prev_reg   <= 1'b1;
    end
    else
    begin
      sclk_sync_reg <= {sclk_sync_reg[0], sclk_i};
      cs_sync_reg   <= {cs_sync_reg[0], cs_n_i};
      sdi_sync_reg  <= {sdi_sync_reg[0], sdi_i};
      sclk_prev_reg <= sclk_sync_reg[1];
      cs_prev_reg   <= cs_sync_reg[1];
    end
  end
  wire sclk_s    = sclk_sync_reg[1];
  wire cs_s      = cs_sync_reg[1];
  wire sclk_rise = sclk_s && !sclk_prev_reg;
  wire sclk_fall = !sclk_s && sclk_prev_reg;
  wire cs_fall   = !cs_s && cs_prev_reg;
  wire cs_rise   = cs_s && !cs_prev_reg;
  wire active    = (state_reg == ST_SHIFT);
  wire at_full   = (cnt_reg == `CNT_FULL);
  wire take_bit  = active && !cs_s && sclk_rise && !at_full;
  wire last_fall = active && sclk_fall && at_full;
  wire [1:0] kind_w = rx_reg[`TYPE_HI:`TYPE_LO];
  wire is_data  = (kind_w == XFER_WR_DAT) || (kind_w == XFER_RD_DAT);
  // The word leaves only when the frame closes complete; a short frame is dropped.
  wire commit   = cs_rise && active && at_full;
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg <= ST_IDLE;
      cnt_reg   <= `CNT_ZERO;
      rx_reg    <= '0;
      tx_reg    <= '0;
      sdo_reg   <= 1'b0;
      oe_n_reg  <= 1'b1;
    end
    else
    begin
      case (state_reg)
        ST_IDLE:
        begin
          if (cs_fall)
          begin
            state_reg <= ST_SHIFT;
            cnt_reg   <= `CNT_ZERO;
            tx_reg    <= reply_i << 1;
            sdo_reg   <= reply_i[WORD_W-1];
            oe_n_reg  <= 1'b0;
          end
        end
        ST_SHIFT:
        begin
          if (cs_rise)
          begin
            state_reg <= ST_IDLE;
            oe_n_reg  <= 1'b1;
          end
          else
          begin
            if (take_bit)
            begin
              rx_reg  <= {rx_reg[WORD_W-2:0], sdi_sync_reg[1]};
              cnt_reg <= cnt_reg + `CNT_ONE;
            end
            if (sclk_fall && !at_full && cnt_reg != `CNT_ZERO)
            begin
              sdo_reg <= tx_reg[WORD_W-1];
              tx_reg  <= tx_reg << 1;
            end
          end
        end
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end
  always_ff @(posedge clk_i or negedge rst_n)
  begin
    if (!rst_n)
    begin
      push_reg       <= 1'b0;
      avail_reg      <= 1'b0;
      data_frame_reg <= 1'b0;
    end
    else
    begin
      push_reg <= commit && in_ready;
      // Both data types end in a zero second bit, so that bit alone marks a data frame.
      if (take_bit && cnt_reg == `CNT_ONE)
        data_frame_reg <= (sdi_sync_reg[1] == 1'b0);
      if (rx_pending_i)
        avail_reg <= 1'b1;
      else if (last_fall && is_data)
        avail_reg <= 1'b0;
    end
  end
  word_fifo #(
    .WIDTH (WORD_W),
    .DEPTH (DEPTH)
  ) u_fifo (
    .clk_i       (clk_i),
    .rst_n_i     (rst_n),
    .in_valid_i  (push_reg),
    .in_ready_o  (in_ready),
    .in_data_i   (rx_reg),
    .out_valid_o (word_valid_o),
    .out_ready_i (word_ready_i),
    .out_data_o  (word_o)
  );
  assign sdo_o       = sdo_reg;
  assign sdo_oe_n_o  = oe_n_reg;
  assign rx_avail_o  = avail_reg;
  assign fifo_full_o = !in_ready;
  property p_oe_off_idle;
    @(posedge clk_i) disable iff (!rst_n) (state_reg == ST_IDLE && !cs_fall) |=> sdo_oe_n_o;
  endproperty
  a_oe_off_idle: assert property (p_oe_off_idle) else $error("output driven while deselected");
  property p_first_bit;
    @(posedge clk_i) disable iff (!rst_n) (state_reg == ST_IDLE && cs_fall) |=> (sdo_o == $past(reply_i[WORD_W-1]));
  endproperty
  a_first_bit: assert property (p_first_bit) else $error("bit 15 not presented at select");
  property p_short_drop;
    @(posedge clk_i) disable iff (!rst_n) (cs_rise && active && !at_full) |=> !push_reg;
  endproperty
  a_short_drop: assert property (p_short_drop) else $error("short frame committed");
  property p_commit;
    @(posedge clk_i) disable iff (!rst_n) (commit && in_ready) |=> push_reg;
  endproperty
  a_commit: assert property (p_commit) else $error("complete frame not committed");
  property p_restart;
    @(posedge clk_i) disable iff (!rst_n) (state_reg == ST_IDLE && cs_fall) |=> (cnt_reg == `CNT_ZERO);
  endproperty
  a_restart: assert property (p_restart) else $error("count not restarted");
  property p_cap16;
    @(posedge clk_i) disable iff (!rst_n) at_full && !cs_rise && active |=> (cnt_reg == `CNT_FULL);
  endproperty
  a_cap16: assert property (p_cap16) else $error("count passed sixteen");
  property p_sample;
    @(posedge clk_i) disable iff (!rst_n) take_bit |=> (rx_reg[0] == $past(sdi_sync_reg[1]));
  endproperty
  a_sample: assert property (p_sample) else $error("input bit not sampled");
  property p_avail_clr;
    @(posedge clk_i) disable iff (!rst_n) (last_fall && data_frame_reg && !rx_pending_i) |=> !rx_avail_o;
  endproperty
  a_avail_clr: assert property (p_avail_clr) else $error("data flag not cleared");
  c_full_frame: cover property (@(posedge clk_i) disable iff (!rst_n) commit);
  c_short_frame: cover property (@(posedge clk_i) disable iff (!rst_n) cs_rise && active && !at_full);
  c_fifo_full: cover property (@(posedge clk_i) disable iff (!rst_n) !in_ready);
endmodule
`default_nettype wire

/* File: verification/spi_master_model.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_master_model (
  input  wire logic clk_i,
  input  wire logic sdo_i,
  output logic      sclk_o,
  output logic      cs_n_o,
  output logic      sdi_o
);
  initial
  begin
    sclk_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o  = 1'b0;
  end
  task automatic tick(input int n);
    repeat (n) @(posedge clk_i);
    #1;
  endtask
  // Fewer than 16 pulses cut the frame short; pulses past 16 are extra.
  task automatic xfer(input logic [15:0] tx, input int n, output logic [15:0] rx);
    rx = 16'h0000;
    tick(1);
    cs_n_o = 1'b0;
    sdi_o = tx[15];
    tick(10);
    for (int i = 0; i < n; i++)
    begin
      sclk_o = 1'b1;
      if (i < 16) rx = {rx[14:0], sdo_i};
      tick(10);
      sclk_o = 1'b0;
      sdi_o = (i < 15) ? tx[14-i] : ~sdi_o;
      tick(10);
    end
    cs_n_o = 1'b1;
    sdi_o = ~sdi_o;
    tick(10);
  endtask
endmodule
`default_nettype wire

/* File: verification/tb_uart_host_serial_port.sv */
`timescale 1ns/1ps
`default_nettype none
module tb_uart_host_serial_port;
  import serial_port_pkg::*;
  logic        clk_i = 1'b0;
  logic        resetn_i = 1'b0;
  logic        rx_pending_i = 1'b0;
  logic        word_ready_i = 1'b0;
  logic [15:0] reply_i = 16'h0000;
  logic [15:0] got;
  logic [15:0] w;
  logic        sclk, cs_n, sdi, sdo, sdo_oe_n, word_valid, rx_avail, fifo_full;
  logic        sdo_last = 1'b0;
  wire logic   sdo_line;
  frame_word_t word;
  logic [15:0] q[$];
  int          miscompares = 0;
  int          n_checks = 0;
  int          cycles = 0;
  always #4 clk_i = ~clk_i;
  // A released output line shows the inverse of its last driven value.
  always @(posedge clk_i)
    if (!sdo_oe_n) sdo_last <= sdo;
  assign sdo_line = sdo_oe_n ? ~sdo_last : sdo;
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      miscompares++;
      print_verdict();
    end
  end
  spi_master_model m_u (.clk_i(clk_i), .sdo_i(sdo_line), .sclk_o(sclk), .cs_n_o(cs_n), .sdi_o(sdi));
  uart_host_serial_port dut_u (
    .clk_i(clk_i), .resetn_i(resetn_i), .sclk_i(sclk), .cs_n_i(cs_n), .sdi_i(sdi),
    .sdo_o(sdo), .sdo_oe_n_o(sdo_oe_n), .reply_i(reply_i), .rx_pending_i(rx_pending_i),
    .word_valid_o(word_valid), .word_ready_i(word_ready_i), .word_o(word),
    .rx_avail_o(rx_avail), .fifo_full_o(fifo_full)
  );
  task automatic print_verdict();
    $display("checks %0d mismatches %0d", n_checks, miscompares);
    if (miscompares == 0 && n_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask
  task automatic cmp_word(input logic [15:0] a, input logic [15:0] e);
    n_checks++;
    if (a !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t word %h expected %h", $time, a, e);
    end
  endtask
  task automatic cmp_bit(input logic a, input logic e);
    n_checks++;
    if (a !== e)
    begin
      miscompares++;
      $display("[FAIL] %0t flag %b expected %b", $time, a, e);
    end
  endtask
  function automatic logic [15:0] mk(input xfer_type_t k);
    return {k, 14'($urandom)};
  endfunction
  task automatic frame(input logic [15:0] tx, input int n);
    reply_i = 16'($urandom);
    m_u.xfer(tx, n, got);
    if (n >= 16) cmp_word(got, reply_i);
    cmp_bit(sdo_oe_n, 1'b1);
  endtask
  task automatic pop(input logic [15:0] e);
    cmp_bit(word_valid, 1'b1);
    cmp_word(word, e);
    word_ready_i = 1'b1;
    @(posedge clk_i);
    #1;
    word_ready_i = 1'b0;
  endtask
  initial
  begin
    void'($urandom(32'hAB4C));
    repeat (3) @(posedge clk_i);
    #1;
    resetn_i = 1'b1;
    cmp_bit(sdo_oe_n, 1'b1);
    cmp_bit(word_valid, 1'b0);
    repeat (4) @(posedge clk_i);
    #1;
    for (int i = 0; i < 17; i++)
    begin
      w = mk(xfer_type_t'(i % 4));
      if (i < 16) q.push_back(w);
      frame(w, 16);
    end
    cmp_bit(fifo_full, 1'b1);
    while (q.size() > 0) pop(q.pop_front());
    cmp_bit(word_valid, 1'b0);
    $display("test types and fifo done");
    frame(mk(XFER_WR_CFG), 9);
    cmp_bit(word_valid, 1'b0);
    w = mk(XFER_RD_DAT);
    frame(w, 18);
    pop(w);
    $display("test abort and extra pulses done");
    rx_pending_i = 1'b1;
    repeat (4) @(posedge clk_i);
    #1;
    cmp_bit(rx_avail, 1'b1);
    rx_pending_i = 1'b0;
    w = mk(XFER_RD_CFG);
    frame(w, 16);
    cmp_bit(rx_avail, 1'b1);
    pop(w);
    w = mk(XFER_WR_DAT);
    frame(w, 16);
    cmp_bit(rx_avail, 1'b0);
    pop(w);
    $display("test data flag done");
    print_verdict();
  end
endmodule
`default_nettype wire
